// ===== fesm_params.svh
// Purpose: offsets, field positions, reset values and timing for the flash
//          erase-suspend and mode control block
// Assumes: register indices are word indices; byte address is index times four
// Notes: timing figures are plain defaults, scale to the real array
`ifndef FESM_PARAMS_SVH
`define FESM_PARAMS_SVH

`define FESM_CLK_MHZ 20
`define FESM_IDX_CTRL0 12'h1B4
`define FESM_IDX_CTRL1 12'h1B5
`define FESM_IDX_SUSP 12'h1B6
`define FESM_IDX_STAT 12'h1B7
`define FESM_IDX_CMD 12'h1B8

`define FESM_C0_REWRITE 1
`define FESM_C0_EWSEL 2
`define FESM_C0_STOP 3
`define FESM_C0_SEQRST 4
`define FESM_C1_BLK_LO 4
`define FESM_C1_BLK_HI 7
`define FESM_SU_EN 0
`define FESM_SU_REQ 1
`define FESM_SU_IRQEN 2
`define FESM_SU_RSV_LO 4
`define FESM_SU_RSV_HI 6
`define FESM_SU_LCR 7
`define FESM_ST_READY 7
`define FESM_ST_SUSP 6
`define FESM_ST_ERR 4
`define FESM_CMD_OP_LO 0
`define FESM_CMD_OP_HI 2
`define FESM_CMD_AREA 3
`define FESM_CMD_BLK_LO 4
`define FESM_CMD_BLK_HI 5

`define FESM_SUSP_RST 8'h00
`define FESM_CTRL_RST 8'h00
`define FESM_AREA_DATA 1'b0
`define FESM_AREA_CODE 1'b1

`define FESM_ERASE_NS 2000
`define FESM_PROG_NS 400
`define FESM_SUSP_LAT_NS 250

`endif

// ===== fesm_pkg.sv
// Purpose: types shared by the flash erase-suspend control files
// Assumes: nothing beyond the parameter header
// Notes: the whole sequencer state is one packed struct
package fesm_pkg;

    typedef enum logic [2:0] {
        OP_NONE,
        OP_ERASE,
        OP_PROG,
        OP_LOCK_PROG,
        OP_LOCK_READ,
        OP_CLR_STAT,
        OP_BLANK
    } fesm_op_t;

    typedef struct packed {
        logic [1:0] blk;
        logic area;
        fesm_op_t op;
    } fesm_cmd_t;

    typedef enum logic [2:0] {
        S_IDLE,
        S_ERASE,
        S_PROG,
        S_SUSP_LAT,
        S_SUSP_ENTER,
        S_SUSP,
        S_SUSP_PROG
    } fesm_seq_t;

    typedef struct packed {
        logic rw_en;
        logic ew_sel;
        logic stop;
        logic [3:0] blk_dis;
        logic sus_en;
        logic sus_req;
        logic irq_en;
        logic [2:0] rsvd;
        logic lcr;
        fesm_seq_t st;
        logic [11:0] ecnt;
        logic [11:0] cnt;
        fesm_cmd_t cur;
        fesm_cmd_t sus_tgt;
        logic rd_arr;
        logic err;
        logic acc;
        logic rej;
        logic rd_ok;
        logic [7:0] rdata;
    } fesm_state_t;

endpackage

// ===== fesm_cmd_gate.sv
// Purpose: decides whether a flash command or an array read is allowed now
// Assumes: all inputs come from flops of the same clock
// Notes: purely combinational; the caller registers what leaves the block
`timescale 1ns/1ns
`include "fesm_params.svh"
module fesm_cmd_gate (
    input wire fesm_pkg::fesm_cmd_t cmd,
    input wire logic rw_en,
    input wire logic stop,
    input wire logic ready,
    input wire logic susp,
    input wire fesm_pkg::fesm_cmd_t sus_tgt,
    input wire fesm_pkg::fesm_cmd_t busy_tgt,
    input wire logic [3:0] blk_dis,
    input wire logic rd_area,
    input wire logic [1:0] rd_blk,
    output logic cmd_ok,
    output logic rd_ok
);
    import fesm_pkg::*;

    function automatic logic same_blk(input logic a, input logic [1:0] b, input fesm_cmd_t t);
        same_blk = (a == t.area) && (b == t.blk);
    endfunction

    logic rewrite_op;

    always_comb begin
        rewrite_op = (cmd.op == OP_ERASE) || (cmd.op == OP_PROG);
        cmd_ok = 1'b1;
        if (!rw_en || stop || cmd.op == OP_NONE) begin
            cmd_ok = 1'b0;
        end else if (cmd.op == OP_CLR_STAT) begin
            cmd_ok = ready;
        end else if (!ready) begin
            cmd_ok = 1'b0;
        end else if (cmd.area == `FESM_AREA_DATA && rewrite_op && blk_dis[cmd.blk]) begin
            cmd_ok = 1'b0;
        end else if (susp) begin
            // erase and blank check stay off; the suspended block is untouchable
            if (cmd.op == OP_ERASE || cmd.op == OP_BLANK) begin
                cmd_ok = 1'b0;
            end else if (same_blk(cmd.area, cmd.blk, sus_tgt)) begin
                cmd_ok = 1'b0;
            end
        end
    end

    always_comb begin
        if (ready) begin
            rd_ok = !(susp && same_blk(rd_area, rd_blk, sus_tgt));
        end else begin
            // background read of code space while the data flash is busy
            rd_ok = (rd_area == `FESM_AREA_CODE) && (busy_tgt.area == `FESM_AREA_DATA);
        end
    end

endmodule

// ===== fesm_ctrl.sv
// Purpose: flash rewrite control: block protect, erase-suspend and resume,
//          erase-while-running mode select, low-current read control
// Assumes: APB master on core_clk; irq_req is an enabled interrupt request
//          from logic on the same clock
// Notes: the array itself is modelled only by busy counters
//        a request left at one while idle suspends the next erase if the enable bit is set,
//        so software clears it before starting one
//        sequence reset keeps the request bit as last written
//        the stop bit only gates commands; nothing is powered down
//
// Overview of operation
// - set disable bit blocks data block rewrites
// - suspend register resets zero, fixed bit layout
// - request set by software or interrupt
// - enabled request suspends erase; clear resumes
// - suspend shows ready first, then suspend flag
// - resume drops ready and suspend flags together
// - rewrite enable accepts commands; mode a default
// - mode b select needs rewrite enable first
// - mode b interrupt suspends after latency
// - suspended block locked; other blocks usable
// - other area programmable and readable during suspend
// - programming can never be suspended
// - suspend command set; clear needs ready
// - array read mode on suspend entry
// - suspend disabled while enable bit zero
// - sequence reset also drops suspend state
// - sequence reset needs rewrite mode and busy or suspend
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ns
`include "fesm_params.svh"
module fesm_ctrl (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [13:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic irq_req,
    input wire logic rd_area,
    input wire logic [1:0] rd_blk,
    output logic rd_allow,
    output logic ready_flag,
    output logic suspend_in_progress_flag,
    output logic array_read_mode,
    output logic low_current_read,
    output logic flash_stop,
    output logic erase_while_run_mode_b,
    output logic cmd_accept,
    output logic cmd_reject
);
    import fesm_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // timing

    localparam logic [11:0] ERASE_CYC =
        12'((`FESM_ERASE_NS * `FESM_CLK_MHZ + 999) / 1000);
    localparam logic [11:0] PROG_CYC =
        12'((`FESM_PROG_NS * `FESM_CLK_MHZ + 999) / 1000);
    localparam logic [11:0] SUSP_LAT_CYC =
        12'((`FESM_SUSP_LAT_NS * `FESM_CLK_MHZ + 999) / 1000);

    localparam logic [2:0] ID_NONE = 3'h0;
    localparam logic [2:0] ID_CTRL0 = 3'h1;
    localparam logic [2:0] ID_CTRL1 = 3'h2;
    localparam logic [2:0] ID_SUSP = 3'h3;
    localparam logic [2:0] ID_STAT = 3'h4;
    localparam logic [2:0] ID_CMD = 3'h5;

    ////////////////////////////////////////////////////////////////////////////
    // decode

    function automatic logic [2:0] reg_id(input logic [13:0] a);
        if (a == {`FESM_IDX_CTRL0, 2'b00}) begin
            reg_id = ID_CTRL0;
        end else if (a == {`FESM_IDX_CTRL1, 2'b00}) begin
            reg_id = ID_CTRL1;
        end else if (a == {`FESM_IDX_SUSP, 2'b00}) begin
            reg_id = ID_SUSP;
        end else if (a == {`FESM_IDX_STAT, 2'b00}) begin
            reg_id = ID_STAT;
        end else if (a == {`FESM_IDX_CMD, 2'b00}) begin
            reg_id = ID_CMD;
        end else begin
            reg_id = ID_NONE;
        end
    endfunction

    function automatic logic starts_work(input logic wr, input logic ok, input fesm_op_t op);
        starts_work = wr && ok && (op != OP_CLR_STAT);
    endfunction

    function automatic logic last_tick(input logic [11:0] c);
        last_tick = (c <= 12'h001);
    endfunction

    fesm_state_t s_q;
    fesm_state_t s_d;

    logic ready;
    logic susp;
    logic erasing;
    logic wr_acc;
    logic [2:0] wr_id;
    logic cmd_wr;
    logic seq_rst;
    logic gate_cmd_ok;
    logic gate_rd_ok;
    logic gate_susp;
    fesm_cmd_t wcmd;

    // ready also covers the one-cycle step before the suspend flag rises
    assign ready = (s_q.st == S_IDLE) || (s_q.st == S_SUSP_ENTER) || (s_q.st == S_SUSP);
    assign susp = (s_q.st == S_SUSP) || (s_q.st == S_SUSP_PROG);
    // interrupts outside an erase are ignored, so a program is never parked
    assign erasing = (s_q.st == S_ERASE) || (s_q.st == S_SUSP_LAT);
    // the step before the suspend flag rises already counts as suspended,
    // so no erase and no access to the halted block slips in there
    assign gate_susp = susp || (s_q.st == S_SUSP_ENTER);
    assign wr_acc = psel && penable && pwrite;
    assign wr_id = reg_id(paddr);
    assign cmd_wr = wr_acc && (wr_id == ID_CMD);
    // a strobe only: never stored, so it reads back as zero
    assign seq_rst = wr_acc && (wr_id == ID_CTRL0) && pwdata[`FESM_C0_SEQRST];

    assign wcmd.op = fesm_op_t'(pwdata[`FESM_CMD_OP_HI:`FESM_CMD_OP_LO]);
    assign wcmd.area = pwdata[`FESM_CMD_AREA];
    assign wcmd.blk = pwdata[`FESM_CMD_BLK_HI:`FESM_CMD_BLK_LO];

    fesm_cmd_gate u_gate (
        .cmd(wcmd),
        .rw_en(s_q.rw_en),
        .stop(s_q.stop),
        .ready(ready),
        .susp(gate_susp),
        .sus_tgt(s_q.sus_tgt),
        .busy_tgt(s_q.cur),
        .blk_dis(s_q.blk_dis),
        .rd_area(rd_area),
        .rd_blk(rd_blk),
        .cmd_ok(gate_cmd_ok),
        .rd_ok(gate_rd_ok)
    );

    ////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        s_d = s_q;
        s_d.acc = 1'b0;
        s_d.rej = 1'b0;
        s_d.rd_ok = gate_rd_ok;

        // read data is captured in the setup cycle so prdata is a flop
        if (psel && !penable) begin
            if (reg_id(paddr) == ID_CTRL0) begin
                s_d.rdata = {4'h0, s_q.stop, s_q.ew_sel, s_q.rw_en, 1'b0};
            end else if (reg_id(paddr) == ID_CTRL1) begin
                s_d.rdata = {s_q.blk_dis, 4'h0};
            end else if (reg_id(paddr) == ID_SUSP) begin
                s_d.rdata = {s_q.lcr, s_q.rsvd, 1'b0, s_q.irq_en, s_q.sus_req, s_q.sus_en};
            end else if (reg_id(paddr) == ID_STAT) begin
                s_d.rdata = {ready, susp, 1'b0, s_q.err, 4'h0};
            end else begin
                s_d.rdata = 8'h00;
            end
        end

        if (wr_acc && wr_id == ID_CTRL0) begin
            s_d.rw_en = pwdata[`FESM_C0_REWRITE];
            // mode b only sticks once rewrite mode was already on
            s_d.ew_sel = s_q.rw_en && pwdata[`FESM_C0_EWSEL];
            s_d.stop = pwdata[`FESM_C0_STOP];
            if (!pwdata[`FESM_C0_REWRITE]) begin
                s_d.blk_dis = 4'h0;
            end
        end
        if (wr_acc && wr_id == ID_CTRL1) begin
            s_d.blk_dis = pwdata[`FESM_C1_BLK_HI:`FESM_C1_BLK_LO];
        end
        if (wr_acc && wr_id == ID_SUSP) begin
            s_d.sus_en = pwdata[`FESM_SU_EN];
            s_d.irq_en = pwdata[`FESM_SU_IRQEN];
            s_d.lcr = pwdata[`FESM_SU_LCR];
            s_d.rsvd = pwdata[`FESM_SU_RSV_HI:`FESM_SU_RSV_LO];
            if (pwdata[`FESM_SU_REQ]) begin
                s_d.sus_req = 1'b1;
            end else if (s_q.rw_en) begin
                s_d.sus_req = 1'b0;
            end
        end
        // an interrupt in the same cycle as a clearing write still wins
        if (s_q.irq_en && irq_req && erasing) begin
            s_d.sus_req = 1'b1;
        end

        if (cmd_wr) begin
            s_d.acc = gate_cmd_ok;
            s_d.rej = !gate_cmd_ok;
            if (!gate_cmd_ok) begin
                s_d.err = 1'b1;
            end else if (wcmd.op == OP_CLR_STAT) begin
                s_d.err = 1'b0;
            end
        end

        case (s_q.st)
            S_IDLE: begin
                // a request bit set here is only stored
                if (starts_work(cmd_wr, gate_cmd_ok, wcmd.op)) begin
                    s_d.cur = wcmd;
                    s_d.rd_arr = 1'b0;
                    if (wcmd.op == OP_ERASE) begin
                        s_d.st = S_ERASE;
                        s_d.ecnt = ERASE_CYC;
                        s_d.sus_tgt = wcmd;
                    end else begin
                        s_d.st = S_PROG;
                        s_d.cnt = PROG_CYC;
                    end
                end
            end
            S_ERASE: begin
                if (last_tick(s_q.ecnt)) begin
                    s_d.st = S_IDLE;
                    s_d.ecnt = 12'h000;
                    s_d.rd_arr = 1'b1;
                end else begin
                    s_d.ecnt = s_q.ecnt - 12'h001;
                    if (s_q.sus_en && s_q.sus_req) begin
                        s_d.st = S_SUSP_LAT;
                        s_d.cnt = SUSP_LAT_CYC;
                    end
                end
            end
            S_PROG: begin
                // no suspend path out of here: programming runs to the end
                if (last_tick(s_q.cnt)) begin
                    s_d.st = S_IDLE;
                    s_d.cnt = 12'h000;
                    s_d.rd_arr = 1'b1;
                end else begin
                    s_d.cnt = s_q.cnt - 12'h001;
                end
            end
            S_SUSP_LAT: begin
                // the erase keeps running until the latency is spent
                if (last_tick(s_q.ecnt)) begin
                    s_d.st = S_IDLE;
                    s_d.ecnt = 12'h000;
                    s_d.rd_arr = 1'b1;
                end else begin
                    s_d.ecnt = s_q.ecnt - 12'h001;
                    if (last_tick(s_q.cnt)) begin
                        s_d.st = S_SUSP_ENTER;
                        s_d.rd_arr = 1'b1;
                    end else begin
                        s_d.cnt = s_q.cnt - 12'h001;
                    end
                end
            end
            S_SUSP_ENTER: begin
                s_d.st = S_SUSP;
            end
            S_SUSP: begin
                if (!s_q.sus_req) begin
                    s_d.st = S_ERASE;
                    s_d.rd_arr = 1'b0;
                end else if (starts_work(cmd_wr, gate_cmd_ok, wcmd.op)) begin
                    s_d.st = S_SUSP_PROG;
                    s_d.cur = wcmd;
                    s_d.cnt = PROG_CYC;
                    s_d.rd_arr = 1'b0;
                end
            end
            S_SUSP_PROG: begin
                if (last_tick(s_q.cnt)) begin
                    s_d.st = S_SUSP;
                    s_d.cnt = 12'h000;
                    s_d.cur = s_q.sus_tgt;
                    s_d.rd_arr = 1'b1;
                end else begin
                    s_d.cnt = s_q.cnt - 12'h001;
                end
            end
            default: begin
                s_d.st = S_IDLE;
            end
        endcase

        // forced stop also throws the suspended erase away
        if (seq_rst && s_q.rw_en && (!ready || susp || s_q.st == S_SUSP_ENTER)) begin
            s_d.st = S_IDLE;
            s_d.ecnt = 12'h000;
            s_d.cnt = 12'h000;
            s_d.rd_arr = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge core_clk) begin
        if (rst) begin
            s_q <= '0;
            s_q.rd_arr <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    assign prdata = {24'h000000, s_q.rdata};
    // every register answers at once: no wait states
    assign pready = 1'b1;
    assign pslverr = psel && penable && (reg_id(paddr) == ID_NONE);
    assign rd_allow = s_q.rd_ok;
    assign ready_flag = ready;
    assign suspend_in_progress_flag = susp;
    assign array_read_mode = s_q.rd_arr;
    assign low_current_read = s_q.lcr;
    assign flash_stop = s_q.stop;
    assign erase_while_run_mode_b = s_q.ew_sel;
    assign cmd_accept = s_q.acc;
    assign cmd_reject = s_q.rej;

endmodule

// ===== fesm_ctrl_asserts.sv
// Purpose: port-level assertions for the flash erase-suspend control block
// Assumes: one clock, synchronous active-high reset
// Notes: apb writes are decoded here from the port signals alone
`timescale 1ns/1ns
`include "fesm_params.svh"
module fesm_ctrl_asserts (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [13:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic ready_flag,
    input wire logic suspend_in_progress_flag,
    input wire logic array_read_mode,
    input wire logic low_current_read,
    input wire logic flash_stop,
    input wire logic erase_while_run_mode_b,
    input wire logic cmd_accept,
    input wire logic cmd_reject
);
    localparam logic [13:0] A_C0 = 14'(`FESM_IDX_CTRL0 * 4);
    localparam logic [13:0] A_SU = 14'(`FESM_IDX_SUSP * 4);
    logic wr_en, su_wr, c0_wr, clr_wr;
    assign wr_en = psel && penable && pwrite;
    assign su_wr = wr_en && paddr == A_SU;
    assign c0_wr = wr_en && paddr == A_C0;
    assign clr_wr = su_wr && !pwdata[1];
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////////////////////
    // the reset check runs during reset too, so it opts out of the default
    a_reset_idle: assert property (disable iff (1'b0)
        rst |=> ready_flag && !suspend_in_progress_flag && array_read_mode)
        else $error("flags wrong after reset");
    a_ready_first: assert property (
        $rose(suspend_in_progress_flag) && !$past(rst) |-> $past(ready_flag) && ready_flag)
        else $error("suspend flag rose without ready first");
    a_resume_both: assert property (
        $fell(suspend_in_progress_flag) && !ready_flag && !$past(rst)
        |-> $past(ready_flag) && ($past(clr_wr) || $past(clr_wr, 2)))
        else $error("resume flags not dropped together");
    a_susp_array: assert property (
        ready_flag && suspend_in_progress_flag |-> array_read_mode)
        else $error("not in array read during suspend");
    a_cmd_pulse: assert property (
        cmd_accept || cmd_reject |=> !cmd_accept && !cmd_reject)
        else $error("command answer longer than one cycle");
    a_lcr_write: assert property (
        su_wr |=> low_current_read == $past(pwdata[7]))
        else $error("low current bit not written");
    a_modeb_cause: assert property (
        $rose(erase_while_run_mode_b) && !$past(rst) |-> $past(c0_wr && pwdata[2]))
        else $error("mode b set without write");
    a_stop_cause: assert property (
        $changed(flash_stop) && !$past(rst) |-> $past(c0_wr))
        else $error("stop bit changed without write");
    cover property ($rose(suspend_in_progress_flag));
    cover property (cmd_reject);
    cover property ($fell(suspend_in_progress_flag) && !ready_flag);
endmodule
bind fesm_ctrl fesm_ctrl_asserts i_fesm_ctrl_asserts (.core_clk, .rst, .psel, .penable,
    .pwrite, .paddr, .pwdata, .ready_flag, .suspend_in_progress_flag, .array_read_mode,
    .low_current_read, .flash_stop, .erase_while_run_mode_b, .cmd_accept, .cmd_reject);

// ===== fesm_cpu_model.sv
// Purpose: cpu core model driving register and command writes over apb
// Assumes: xfer is entered just after a rising edge
// Notes: released address and data are inverted so stale values never match
`timescale 1ns/1ns
module fesm_cpu_model (
    input wire logic core_clk,
    input wire logic [31:0] prdata,
    input wire logic pready,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [13:0] paddr,
    output logic [31:0] pwdata
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 14'h0;
        pwdata = 32'h0;
    end
    // ends at the edge where the answer was taken; caller adds any idle cycle
    task automatic xfer(input logic w, input logic [13:0] a, input logic [7:0] d,
        output logic [31:0] q);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~a;
        pwdata <= ~{24'h0, d};
    endtask
endmodule

// ===== fesm_ctrl_test.sv
// Purpose: self-checking bench for the flash erase-suspend control block
// Assumes: erase and program lengths as set in the parameter header
// Notes: commands always wait for ready; one idle cycle after each register access, three after a command
`timescale 1ns/1ns
`include "fesm_params.svh"
module fesm_ctrl_test;
    import fesm_pkg::*;
    localparam logic [13:0] A_C0 = 14'(`FESM_IDX_CTRL0 * 4);
    localparam logic [13:0] A_C1 = 14'(`FESM_IDX_CTRL1 * 4);
    localparam logic [13:0] A_SU = 14'(`FESM_IDX_SUSP * 4);
    localparam logic [13:0] A_CMD = 14'(`FESM_IDX_CMD * 4);
    logic core_clk, rst, psel, penable, pwrite, pready, pslverr, irq_req, rd_area, rd_allow;
    logic ready_flag, suspend_in_progress_flag, array_read_mode, low_current_read;
    logic flash_stop, erase_while_run_mode_b, cmd_accept, cmd_reject, s0;
    logic [13:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [1:0] rd_blk, r;
    int fail_count, tests_run;
    fesm_op_t t_op[9] = '{OP_ERASE, OP_PROG, OP_BLANK, OP_PROG, OP_PROG, OP_ERASE,
        OP_LOCK_PROG, OP_LOCK_READ, OP_CLR_STAT};
    logic [1:0] t_bk[9] = '{2'h2, 2'h1, 2'h2, 2'h2, 2'h0, 2'h0, 2'h1, 2'h3, 2'h0};
    logic [8:0] t_code = 9'h070;
    logic [8:0] t_acc = 9'h1D8;
    fesm_ctrl i_fesm_ctrl (.core_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .irq_req, .rd_area, .rd_blk, .rd_allow, .ready_flag,
        .suspend_in_progress_flag, .array_read_mode, .low_current_read, .flash_stop,
        .erase_while_run_mode_b, .cmd_accept, .cmd_reject);
    fesm_cpu_model i_fesm_cpu_model (.core_clk, .prdata, .pready, .psel, .penable,
        .pwrite, .paddr, .pwdata);
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        tests_run++;
        if (s !== e) begin
            fail_count++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wr(input logic [13:0] a, input logic [7:0] d);
        i_fesm_cpu_model.xfer(1'b1, a, d, q);
        @(posedge core_clk);
    endtask
    task automatic rd(input logic [13:0] a);
        i_fesm_cpu_model.xfer(1'b0, a, 8'h00, q);
        @(posedge core_clk);
    endtask
    // the answer pulse lasts one cycle, so sample every cycle after the write
    task automatic cmd(input fesm_op_t op, input logic ar, input logic [1:0] b);
        r = 2'b00;
        i_fesm_cpu_model.xfer(1'b1, A_CMD, {2'b00, b, ar, op}, q);
        repeat (3) begin
            #1;
            r = r | {cmd_accept, cmd_reject};
            @(posedge core_clk);
        end
    endtask
    // polls every cycle so the single ready step before suspend is caught
    task automatic wait_rdy;
        int n;
        n = 0;
        #1;
        while (ready_flag !== 1'b1 && n < 300) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        s0 = suspend_in_progress_flag;
        chk("ready wait", 32'(n < 300), 32'h1);
        @(posedge core_clk);
    endtask
    task automatic summarize;
        if (fail_count == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    initial begin
        #(50 * 4000);
        fail_count++;
        summarize;
    end
    initial begin
        fail_count = 0;
        tests_run = 0;
        rst = 1'b1;
        irq_req = 1'b0;
        rd_area = 1'b0;
        rd_blk = 2'h0;
        repeat (10) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        rd(A_SU);
        chk("susp reset", q, 32'h0);
        i_fesm_cpu_model.xfer(1'b0, 14'h0000, 8'h00, q);
        chk("unmapped error", pslverr, 1'b1);
        @(posedge core_clk);
        wr(A_SU, 8'h00);
        wr(A_SU, 8'h8F);
        rd(A_SU);
        chk("susp bits", q, 32'h87);
        chk("low current", low_current_read, 1'b1);
        wr(A_SU, 8'h00);
        rd(A_SU);
        chk("clear without rewrite", q, 32'h02);
        wr(A_C0, 8'h04);
        chk("mode b early", erase_while_run_mode_b, 1'b0);
        wr(A_C0, 8'h02);
        wr(A_C0, 8'h06);
        chk("mode b", erase_while_run_mode_b, 1'b1);
        wr(A_C0, 8'h02);
        chk("mode a", erase_while_run_mode_b, 1'b0);
        wr(A_C0, 8'h0A);
        chk("stop on", flash_stop, 1'b1);
        wr(A_C0, 8'h02);
        chk("stop off", flash_stop, 1'b0);
        wr(A_SU, 8'h00);
        rd(A_SU);
        chk("request cleared", q, 32'h0);
        wr(A_C1, 8'h10);
        cmd(OP_ERASE, `FESM_AREA_DATA, 2'h0);
        chk("protected block", r, 2'b01);
        wr(A_C1, 8'h00);
        wr(A_SU, 8'h02);
        cmd(OP_ERASE, `FESM_AREA_DATA, 2'h0);
        chk("open block", r, 2'b10);
        wait_rdy;
        chk("no suspend while disabled", s0, 1'b0);
        wr(A_SU, 8'h00);
        wr(A_SU, 8'h01);
        cmd(OP_ERASE, `FESM_AREA_DATA, 2'h1);
        chk("erase accept", r, 2'b10);
        chk("array read off", array_read_mode, 1'b0);
        wr(A_SU, 8'h03);
        wait_rdy;
        chk("ready before suspend", s0, 1'b0);
        rd_blk <= 2'h1;
        #1;
        chk("suspended", suspend_in_progress_flag, 1'b1);
        chk("array read", array_read_mode, 1'b1);
        @(posedge core_clk);
        @(posedge core_clk);
        rd_blk <= 2'h2;
        #1;
        chk("read suspended block", rd_allow, 1'b0);
        @(posedge core_clk);
        @(posedge core_clk);
        #1;
        chk("read other block", rd_allow, 1'b1);
        @(posedge core_clk);
        for (int i = 0; i < 9; i++) begin
            cmd(t_op[i], t_code[i], t_bk[i]);
            chk("suspend command", r, t_acc[i] ? 2'b10 : 2'b01);
            wait_rdy;
        end
        chk("still suspended", s0, 1'b1);
        wr(A_SU, 8'h01);
        #1;
        chk("resume ready", ready_flag, 1'b0);
        chk("resume flag", suspend_in_progress_flag, 1'b0);
        wait_rdy;
        chk("erase done", s0, 1'b0);
        cmd(OP_PROG, `FESM_AREA_DATA, 2'h0);
        chk("program accept", r, 2'b10);
        wr(A_SU, 8'h03);
        wait_rdy;
        #1;
        chk("program not suspended", suspend_in_progress_flag, 1'b0);
        chk("idle request", ready_flag, 1'b1);
        @(posedge core_clk);
        wr(A_SU, 8'h01);
        wr(A_C0, 8'h06);
        wr(A_SU, 8'h00);
        wr(A_SU, 8'h05);
        cmd(OP_ERASE, `FESM_AREA_CODE, 2'h2);
        chk("code erase accept", r, 2'b10);
        irq_req <= 1'b1;
        @(posedge core_clk);
        irq_req <= 1'b0;
        rd(A_SU);
        chk("irq request", q, 32'h07);
        wait_rdy;
        #1;
        chk("irq suspend", suspend_in_progress_flag, 1'b1);
        @(posedge core_clk);
        wr(A_C0, 8'h16);
        #1;
        chk("reset suspend", suspend_in_progress_flag, 1'b0);
        chk("reset ready", ready_flag, 1'b1);
        summarize;
    end
endmodule
